/* File: common/ssr_regs.vh */
`ifndef SSR_REGS_VH
`define SSR_REGS_VH
// Memory geometry.
`define SSR_ADDR_W 7
`define SSR_DATA_W 8
// Timing figures in ns, worst case over temperature.
`define SSR_CLK_NS 4
`define SSR_T_AS_NS 100
`define SSR_T_WW_NS 200
`define SSR_T_AH_NS 100
`define SSR_T_DS_NS 100
`define SSR_T_CS_NS 300
`define SSR_T_AC_NS 505
`define SSR_T_DH_NS 70
// Cycle counts, least times rounded up.
`define SSR_CYC(ns) (((ns) + `SSR_CLK_NS - 1) / `SSR_CLK_NS)
`define SSR_AS_CYC `SSR_CYC(`SSR_T_AS_NS)
`define SSR_WW_CYC `SSR_CYC(`SSR_T_WW_NS)
`define SSR_AH_CYC `SSR_CYC(`SSR_T_AH_NS)
`define SSR_CS_CYC `SSR_CYC(`SSR_T_CS_NS)
`define SSR_AC_CYC `SSR_CYC(`SSR_T_AC_NS)
`define SSR_DH_CYC `SSR_CYC(`SSR_T_DH_NS)
`endif

/* File: hw/ssr_host.v */
`timescale 1ns/1ns
`include "ssr_regs.vh"
// Behaviour
// - Select lows two, three, five driven low.
// - Select highs one and four driven high.
// - Read strobe stays high during writes.
// - Write strobe stays high during reads.
// - Address may change after data valid.
module ssr_host #(
    parameter AW = `SSR_ADDR_W,
    parameter DW = `SSR_DATA_W
) (
    input  wire          clk,
    input  wire          rstn,
    input  wire          req_valid,
    input  wire          req_write,
    input  wire [AW-1:0] req_addr,
    input  wire [DW-1:0] req_wdata,
    output reg           req_ready,
    output reg           rsp_valid,
    output reg  [DW-1:0] rsp_rdata,
    output reg  [AW-1:0] mem_addr,
    input  wire [DW-1:0] bus_in,
    output reg  [DW-1:0] bus_out,
    output reg           bus_oe,
    output reg           read_strobe_n,
    output reg           write_strobe_n,
    output reg           select_high_a,
    output reg           select_low_a,
    output reg           select_low_b,
    output reg           select_high_b,
    output reg           select_low_c
);
    // One-hot phase codes of the access sequencer.
    localparam [5:0] ST_IDLE  = 6'h01;
    localparam [5:0] ST_SETUP = 6'h02;
    localparam [5:0] ST_WPULS = 6'h04;
    localparam [5:0] ST_WHOLD = 6'h08;
    localparam [5:0] ST_RWAIT = 6'h10;
    localparam [5:0] ST_RHOLD = 6'h20;

    // Phase lengths in clock cycles, computed wide and then cut to the counter's width.
    localparam integer AS_INT = `SSR_AS_CYC;
    localparam integer WW_INT = `SSR_WW_CYC;
    localparam integer AH_INT = `SSR_AH_CYC;
    localparam integer CS_INT = `SSR_CS_CYC;
    // Two extra cycles cover the synchroniser on the read path.
    localparam integer AC_INT = `SSR_AC_CYC + 2;
    localparam integer DH_INT = `SSR_DH_CYC;
    localparam [9:0]   AS_CYC = AS_INT[9:0];
    localparam [9:0]   WW_CYC = WW_INT[9:0];
    localparam [9:0]   AH_CYC = AH_INT[9:0];
    localparam [9:0]   CS_CYC = CS_INT[9:0];
    localparam [9:0]   AC_CYC = AC_INT[9:0];
    localparam [9:0]   DH_CYC = DH_INT[9:0];

    // Larger of two cycle counts.
    function [9:0] max_cyc;
        input [9:0] a;
        input [9:0] b;
        begin
            max_cyc = (a > b) ? a : b;
        end
    endfunction

    // High on the last cycle of a phase that lasts limit cycles.
    function cnt_done;
        input [9:0] cnt;
        input [9:0] limit;
        begin
            cnt_done = (cnt + 10'h001 >= limit);
        end
    endfunction

    // The write strobe also covers the select setup left after the address setup.
    localparam [9:0]   WP_CYC = max_cyc(WW_CYC, CS_CYC - AS_CYC);
    // Address and data both stay put past the write strobe's rise.
    localparam [9:0]   WH_CYC = max_cyc(AH_CYC, DH_CYC);

    // Phase, cycle count within the phase and kind of access in progress.
    reg  [5:0]    state;
    reg  [9:0]    count;
    reg           is_write;
    wire [DW-1:0] bus_sync;

    // Read data passes two flip-flops before it is captured.
    ssr_sync #(.W(DW)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .din  (bus_in),
        .dout (bus_sync)
    );

    // Drives selects to the active pattern, or all to inactive.
    task drive_select;
        input on;
        begin
            select_high_a <= on;
            select_high_b <= on;
            select_low_a  <= ~on;
            select_low_b  <= ~on;
            select_low_c  <= ~on;
        end
    endtask

    // Sequences one access at a time over the memory pins.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state          <= ST_IDLE;
            count          <= 10'h000;
            is_write       <= 1'b0;
            req_ready      <= 1'b0;
            rsp_valid      <= 1'b0;
            rsp_rdata      <= {DW{1'b0}};
            mem_addr       <= {AW{1'b0}};
            bus_out        <= {DW{1'b0}};
            bus_oe         <= 1'b0;
            read_strobe_n  <= 1'b1;
            write_strobe_n <= 1'b1;
            select_high_a  <= 1'b0;
            select_high_b  <= 1'b0;
            select_low_a   <= 1'b1;
            select_low_b   <= 1'b1;
            select_low_c   <= 1'b1;
        end else begin
            // The response strobe lasts a single cycle.
            rsp_valid <= 1'b0;
            case (state)
                ST_IDLE: begin
                    // Deselected with both strobes high: no access.
                    read_strobe_n  <= 1'b1;
                    write_strobe_n <= 1'b1;
                    bus_oe         <= 1'b0;
                    drive_select(1'b0);
                    req_ready      <= 1'b1;
                    if (req_valid && req_ready) begin
                        // Take the request and raise the selects at once.
                        req_ready <= 1'b0;
                        is_write  <= req_write;
                        mem_addr  <= req_addr;
                        bus_out   <= req_wdata;
                        bus_oe    <= req_write;
                        drive_select(1'b1);
                        count     <= 10'h000;
                        state     <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    // Address, data and selects settle before a strobe falls.
                    count <= count + 10'h001;
                    if (is_write) begin
                        if (cnt_done(count, AS_CYC)) begin
                            // Read strobe stays high while we drive data.
                            read_strobe_n  <= 1'b1;
                            write_strobe_n <= 1'b0;
                            count          <= 10'h000;
                            state          <= ST_WPULS;
                        end
                    end else begin
                        // Write strobe held high throughout the read.
                        write_strobe_n <= 1'b1;
                        read_strobe_n  <= 1'b0;
                        count          <= 10'h000;
                        state          <= ST_RWAIT;
                    end
                end
                ST_WPULS: begin
                    // Write strobe held low for the whole pulse.
                    count <= count + 10'h001;
                    if (cnt_done(count, WP_CYC)) begin
                        write_strobe_n <= 1'b1;
                        count          <= 10'h000;
                        state          <= ST_WHOLD;
                    end
                end
                ST_WHOLD: begin
                    // Address and data held past the strobe's rise.
                    count <= count + 10'h001;
                    if (cnt_done(count, WH_CYC)) begin
                        // Bus released together with the selects.
                        bus_oe    <= 1'b0;
                        drive_select(1'b0);
                        req_ready <= 1'b1;
                        state     <= ST_IDLE;
                    end
                end
                ST_RWAIT: begin
                    // Wait access time plus synchroniser delay, then sample.
                    count <= count + 10'h001;
                    if (cnt_done(count, AC_CYC)) begin
                        // Sampled while the read strobe is still low.
                        rsp_rdata     <= bus_sync;
                        rsp_valid     <= 1'b1;
                        read_strobe_n <= 1'b1;
                        count         <= 10'h000;
                        state         <= ST_RHOLD;
                    end
                end
                ST_RHOLD: begin
                    // Device keeps driving for a hold time after the strobe.
                    count <= count + 10'h001;
                    if (cnt_done(count, DH_CYC)) begin
                        // Selects released and the next request invited.
                        drive_select(1'b0);
                        req_ready <= 1'b1;
                        state     <= ST_IDLE;
                    end
                end
                default: begin
                    // Any stray code falls back to idle.
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule

/* File: hw/ssr_sync.v */
`timescale 1ns/1ns
`include "ssr_regs.vh"
// Two-stage synchroniser for the data bus read back from the pins.
module ssr_sync #(
    parameter W = 8
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] meta;

    // First stage feeds only the second stage.
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= {W{1'b0}};
            dout <= {W{1'b0}};
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

/* File: verif/ssr_host_asserts.sv */
`timescale 1ns/1ns
// Watches the pin sequencing that the host drives towards the memory.
module ssr_host_chk (
    input wire clk,
    input wire rstn,
    input wire req_ready,
    input wire rsp_valid,
    input wire bus_oe,
    input wire read_strobe_n,
    input wire write_strobe_n,
    input wire select_high_a,
    input wire select_low_a,
    input wire select_low_b,
    input wire select_high_b,
    input wire select_low_c
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // Decoded select and active strobes.
    wire sel = select_high_a & select_high_b & ~select_low_a & ~select_low_b & ~select_low_c;
    wire rd  = ~read_strobe_n;
    wire wr  = ~write_strobe_n;
    AST_RD_SEL: assert property (rd |-> sel) else $error("read unselected");
    AST_WR_SEL: assert property (wr |-> sel) else $error("write unselected");
    AST_WR_RDHI: assert property (wr |-> !rd && bus_oe) else $error("write bad");
    AST_RD_WRHI: assert property (rd |-> !wr && !bus_oe) else $error("read bad");
    AST_WR_LEN: assert property ($rose(wr) |-> wr [*8]) else $error("write short");
    AST_RD_RSP: assert property ($rose(rd) |-> ##[127:131] rsp_valid) else $error("no rsp");
    AST_RSP_RD: assert property (rsp_valid |-> $past(rd)) else $error("rsp late");
    AST_BUSY: assert property (rd || wr |-> !req_ready) else $error("ready busy");
    // Length of the current write pulse in cycles.
    reg [7:0] wr_len;
    always @(posedge clk or negedge rstn) begin
        if (!rstn) wr_len <= 8'h00;
        else if (wr) wr_len <= wr_len + 8'h01;
        else wr_len <= 8'h00;
    end
    AST_WR_MIN: assert property ($fell(wr) |-> wr_len >= 8'h32) else $error("pulse short");
    cover property ($rose(wr));
    cover property ($rose(rd));
    cover property (rsp_valid);
endmodule
bind ssr_host ssr_host_chk u_ssr_host_chk (.clk(clk), .rstn(rstn), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .bus_oe(bus_oe), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .select_high_a(select_high_a), .select_low_a(select_low_a),
    .select_low_b(select_low_b), .select_high_b(select_high_b), .select_low_c(select_low_c));

/* File: verif/ssr_sram.sv */
`timescale 1ns/1ns
// Behavioural static memory; select order is high_a, low_a, low_b, high_b, low_c.
module ssr_sram (
    input  wire [6:0] addr,
    input  wire [7:0] bus,
    input  wire       rd_n,
    input  wire       wr_n,
    input  wire [4:0] cs,
    output wire       oe,
    output wire [7:0] q
);
    reg  [7:0] mem [0:127];
    reg  [7:0] last;
    wire       sel = (cs === 5'h12);
    // Drives the word on a selected read; a released bus shows the inverse.
    assign oe = sel & ~rd_n;
    assign q  = oe ? mem[addr] : ~last;
    always @* if (oe) last = mem[addr];
    // Stores the bus when a selected write ends with the read strobe high.
    always @(posedge wr_n) if (sel && rd_n) mem[addr] <= bus;
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    reg        clk = 1'b0, rstn = 1'b0, req_valid = 1'b0, req_write = 1'b0;
    reg  [6:0] req_addr = 7'h00;
    reg  [7:0] req_wdata = 8'h00;
    wire       req_ready, rsp_valid, bus_oe, read_strobe_n, write_strobe_n, m_oe;
    wire [7:0] rsp_rdata, bus_out, m_q;
    wire [6:0] mem_addr;
    wire [4:0] cs;
    integer    failures = 0, compares = 0;
    // Resolved bus level fed back to the host; a clash of both drivers inverts the word.
    wire [7:0] bus_in = bus_oe ? (m_oe ? ~bus_out : bus_out) : m_q;
    always #2 clk = ~clk;
    ssr_host u_ssr_host (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(mem_addr), .bus_in(bus_in),
        .bus_out(bus_out), .bus_oe(bus_oe), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .select_high_a(cs[4]), .select_low_a(cs[3]),
        .select_low_b(cs[2]), .select_high_b(cs[1]), .select_low_c(cs[0]));
    ssr_sram u_ssr_sram (.addr(mem_addr), .bus(bus_in), .rd_n(read_strobe_n),
        .wr_n(write_strobe_n), .cs(cs), .oe(m_oe), .q(m_q));
    // Hands over one request and checks the word that a read returns.
    task access(input reg w, input reg [6:0] a, input reg [7:0] d);
        integer i;
        begin
            do @(negedge clk); while (req_ready !== 1'b1);
            @(posedge clk);
            req_valid <= 1'b1;
            req_write <= w;
            req_addr <= a;
            req_wdata <= d;
            @(posedge clk);
            req_valid <= 1'b0;
            @(negedge clk);
            `CHK(req_ready, 1'b0)
            for (i = 0; i < 300 && !w && rsp_valid !== 1'b1; i++) @(negedge clk);
            if (!w) `CHK({rsp_valid, rsp_rdata}, {1'b1, d})
        end
    endtask
    // Writes both ends of the address range, then reads them back.
    task t_ends;
        begin
            access(1'b1, 7'h00, 8'hA5);
            access(1'b1, 7'h7F, 8'h5A);
            access(1'b0, 7'h00, 8'hA5);
            access(1'b0, 7'h7F, 8'h5A);
        end
    endtask
    // Overwrites word 0x7F and reads it and word 0x00 back to back.
    task t_overwrite;
        begin
            access(1'b1, 7'h7F, 8'hC3);
            access(1'b0, 7'h7F, 8'hC3);
            access(1'b0, 7'h00, 8'hA5);
        end
    endtask
    // Prints the verdict and ends the run.
    task complete_run;
        begin
            if (failures == 0 && compares > 0) $display("TB: PASS");
            else $display("TB: FAIL");
            $finish;
        end
    endtask
    // Main sequence after four cycles of reset.
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        t_ends;
        t_overwrite;
        complete_run;
    end
    // Watchdog well beyond seven accesses of some 100 to 150 cycles each.
    initial begin
        #20000;
        failures++;
        complete_run;
    end
endmodule
